// ---- include/ssb_params.svh ----
// Register offsets, field positions, reset values and timing counts of the burst transmitter
`ifndef SSB_PARAMS_SVH
`define SSB_PARAMS_SVH

// Register indices; byte address is four times the index
`define SSB_IDX_FCW0 8'h03
`define SSB_IDX_FCW3 8'h06
`define SSB_IDX_START 8'h37
`define SSB_IDX_MODE 8'h40
`define SSB_IDX_DCHIPS 8'h42
`define SSB_IDX_PCHIPS 8'h43
`define SSB_IDX_PCODE0 8'h44
`define SSB_IDX_PCODE7 8'h4B
`define SSB_IDX_DCODE0 8'h4C
`define SSB_IDX_DCODE7 8'h53
`define SSB_IDX_CHDIV 8'h60
`define SSB_IDX_CFG 8'h61
`define SSB_IDX_BLEN0 8'h62
`define SSB_IDX_BLEN1 8'h63
`define SSB_IDX_STATUS 8'h64

// Field positions
`define SSB_START_BIT 1
`define SSB_BPSK_BIT 0
`define SSB_EXTREF_BIT 0

// Reset values
`define SSB_CHDIV_RST 8'h07
`define SSB_BLEN_RST 16'h0004

// Timing: full code length in chips, and bit capture delay after a request in clocks
`define SSB_MAX_CHIPS 7'h40
`define SSB_BIT_LAT 3'h4

`endif

// ---- include/ssb_pkg.sv ----
// Types shared by the burst transmitter
package ssb_pkg;
    typedef enum logic [1:0] {S_IDLE, S_PRE, S_DATA} ssb_state_t;
    typedef struct packed {
        logic i;
        logic q;
    } ssb_pair_t;
    typedef struct packed {
        logic [7:0] idx;
        logic wr;
        logic rd;
    } ssb_ap_t;
endpackage

// ---- rtl/ssb_sine_rom.sv ----
// Sine and cosine lookup for the NCO, registered outputs
`timescale 1ns/1ns
module ssb_sine_rom (
    // Clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // Phase in, samples out
    input wire logic [3:0] phase_i,
    output logic signed [7:0] sin_o,
    output logic signed [7:0] cos_o
);
    // Sixteen points per cycle; coarse, but keeps the table small
    function automatic logic [7:0] sine_at(input logic [3:0] p);
        logic [7:0] v;
        v = 8'h00;
        case (p)
            4'h0: v = 8'h00;
            4'h1: v = 8'h31;
            4'h2: v = 8'h5A;
            4'h3: v = 8'h75;
            4'h4: v = 8'h7F;
            4'h5: v = 8'h75;
            4'h6: v = 8'h5A;
            4'h7: v = 8'h31;
            4'h8: v = 8'h00;
            4'h9: v = 8'hCF;
            4'hA: v = 8'hA6;
            4'hB: v = 8'h8B;
            4'hC: v = 8'h81;
            4'hD: v = 8'h8B;
            4'hE: v = 8'hA6;
            default: v = 8'hCF;
        endcase
        return v;
    endfunction

    // Cosine is the sine a quarter cycle ahead
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sin_o <= 8'h00;
            cos_o <= 8'h00;
        end else begin
            sin_o <= sine_at(phase_i);
            cos_o <= sine_at(phase_i + 4'h4);
        end
    end
endmodule

// ---- rtl/ssb_burst_tx.sv ----
// Burst spread-spectrum transmitter: register slave, timing, encoder, spreader, modulator
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ns
`include "ssb_params.svh"
module ssb_burst_tx (
    // Clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Burst control and serial data source
    input wire logic tx_burst_enable_pin_i,
    input wire logic ext_tx_chip_ref_i,
    input wire logic tx_serial_in_i,
    output logic tx_bit_request_o,
    output logic preamble_done_pulse_o,
    output logic data_symbol_pulse_o,
    // Spread chips and IF samples
    output logic spread_i_out_o,
    output logic spread_q_out_o,
    output logic [7:0] modulated_if_out_o
);
    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [31:0] fcw_ff;
    logic [7:0] start_ff, mode_ff, dchip_ff, pchip_ff, chdiv_ff, cfg_ff;
    logic [63:0] pcode_ff, dcode_ff;
    logic [15:0] blen_ff, remain_ff;
    logic [31:0] hrdata_ff, phase_ff;
    logic hready_ff, hresp_ff;
    ssb_pkg::ssb_ap_t ap_ff;
    logic [7:0] rd_mux;
    logic [2:0] sync_s1_ff, sync_s2_ff;
    logic en_d_ff, sw_d_ff, ref_d_ff;
    logic [7:0] div_cnt_ff;
    ssb_pkg::ssb_state_t state_ff;
    logic [5:0] idx_ff;
    ssb_pkg::ssb_pair_t enc_ff, fetched_ff, enc_next;
    logic bpsk_ff, busy, chip_en, sym_last, start_evt, start_fetch, code_bit;
    logic [6:0] sym_len;
    logic [1:0] left_ff, nbits;
    logic [2:0] lat_ff;
    logic slot_ff, req_ff, pre_done_ff, data_pls_ff;
    logic spread_i_ff, spread_q_ff;
    logic [7:0] if_ff;
    logic signed [7:0] nco_sin, nco_cos;
    logic signed [8:0] term_i, term_q, if_sum;
    wire logic ap_ok = hsel_i && htrans_i[1] && hready_i;

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave

    // Reads take one wait state so a write just before them is seen
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ap_ff <= '0;
            hready_ff <= 1'b1;
            hresp_ff <= 1'b0;
            hrdata_ff <= 32'h0000_0000;
        end else begin
            ap_ff.wr <= ap_ok && hwrite_i;
            ap_ff.rd <= ap_ok && !hwrite_i;
            if (ap_ok) begin
                ap_ff.idx <= haddr_i[9:2];
            end
            hready_ff <= !(ap_ok && !hwrite_i);
            hresp_ff <= 1'b0;
            if (ap_ff.rd) begin
                hrdata_ff <= {24'h00_0000, rd_mux};
            end
        end
    end

    // Read decode; unmapped indices read zero
    always_comb begin
        rd_mux = 8'h00;
        if (ap_ff.idx >= `SSB_IDX_FCW0 && ap_ff.idx <= `SSB_IDX_FCW3) begin
            rd_mux = fcw_ff[{2'(ap_ff.idx[1:0] - 2'h3), 3'h0} +: 8];
        end else if (ap_ff.idx == `SSB_IDX_START) begin
            rd_mux = start_ff;
        end else if (ap_ff.idx == `SSB_IDX_MODE) begin
            rd_mux = mode_ff;
        end else if (ap_ff.idx == `SSB_IDX_DCHIPS) begin
            rd_mux = dchip_ff;
        end else if (ap_ff.idx == `SSB_IDX_PCHIPS) begin
            rd_mux = pchip_ff;
        end else if (ap_ff.idx >= `SSB_IDX_PCODE0 && ap_ff.idx <= `SSB_IDX_PCODE7) begin
            rd_mux = pcode_ff[{3'(ap_ff.idx[2:0] - 3'h4), 3'h0} +: 8];
        end else if (ap_ff.idx >= `SSB_IDX_DCODE0 && ap_ff.idx <= `SSB_IDX_DCODE7) begin
            rd_mux = dcode_ff[{3'(ap_ff.idx[2:0] - 3'h4), 3'h0} +: 8];
        end else if (ap_ff.idx == `SSB_IDX_CHDIV) begin
            rd_mux = chdiv_ff;
        end else if (ap_ff.idx == `SSB_IDX_CFG) begin
            rd_mux = cfg_ff;
        end else if (ap_ff.idx == `SSB_IDX_BLEN0) begin
            rd_mux = blen_ff[7:0];
        end else if (ap_ff.idx == `SSB_IDX_BLEN1) begin
            rd_mux = blen_ff[15:8];
        end else if (ap_ff.idx == `SSB_IDX_STATUS) begin
            rd_mux = {5'h00, state_ff == ssb_pkg::S_DATA, state_ff == ssb_pkg::S_PRE, busy};
        end
    end

    // Register writes in the data phase, low byte only
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            fcw_ff <= 32'h0000_0000;
            start_ff <= 8'h00;
            mode_ff <= 8'h00;
            dchip_ff <= 8'h00;
            pchip_ff <= 8'h00;
            pcode_ff <= 64'h0;
            dcode_ff <= 64'h0;
            chdiv_ff <= `SSB_CHDIV_RST;
            cfg_ff <= 8'h00;
            blen_ff <= `SSB_BLEN_RST;
        end else if (ap_ff.wr) begin
            if (ap_ff.idx >= `SSB_IDX_FCW0 && ap_ff.idx <= `SSB_IDX_FCW3) begin
                fcw_ff[{2'(ap_ff.idx[1:0] - 2'h3), 3'h0} +: 8] <= hwdata_i[7:0];
            end else if (ap_ff.idx == `SSB_IDX_START) begin
                start_ff <= hwdata_i[7:0];
            end else if (ap_ff.idx == `SSB_IDX_MODE) begin
                mode_ff <= hwdata_i[7:0];
            end else if (ap_ff.idx == `SSB_IDX_DCHIPS) begin
                dchip_ff <= hwdata_i[7:0];
            end else if (ap_ff.idx == `SSB_IDX_PCHIPS) begin
                pchip_ff <= hwdata_i[7:0];
            end else if (ap_ff.idx >= `SSB_IDX_PCODE0 && ap_ff.idx <= `SSB_IDX_PCODE7) begin
                pcode_ff[{3'(ap_ff.idx[2:0] - 3'h4), 3'h0} +: 8] <= hwdata_i[7:0];
            end else if (ap_ff.idx >= `SSB_IDX_DCODE0 && ap_ff.idx <= `SSB_IDX_DCODE7) begin
                dcode_ff[{3'(ap_ff.idx[2:0] - 3'h4), 3'h0} +: 8] <= hwdata_i[7:0];
            end else if (ap_ff.idx == `SSB_IDX_CHDIV) begin
                chdiv_ff <= hwdata_i[7:0];
            end else if (ap_ff.idx == `SSB_IDX_CFG) begin
                cfg_ff <= hwdata_i[7:0];
            end else if (ap_ff.idx == `SSB_IDX_BLEN0) begin
                blen_ff[7:0] <= hwdata_i[7:0];
            end else if (ap_ff.idx == `SSB_IDX_BLEN1) begin
                blen_ff[15:8] <= hwdata_i[7:0];
            end
        end
    end

    assign hrdata_o = hrdata_ff;
    assign hreadyout_o = hready_ff;
    assign hresp_o = hresp_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and start detection

    // Bit 0 enable pin, bit 1 chip reference, bit 2 serial data
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sync_s1_ff <= 3'h0;
            sync_s2_ff <= 3'h0;
        end else begin
            sync_s1_ff <= {tx_serial_in_i, ext_tx_chip_ref_i, tx_burst_enable_pin_i};
            sync_s2_ff <= sync_s1_ff;
        end
    end

    // Edge memories for pin, start bit and chip reference
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            en_d_ff <= 1'b0;
            sw_d_ff <= 1'b0;
            ref_d_ff <= 1'b0;
        end else begin
            en_d_ff <= sync_s2_ff[0];
            sw_d_ff <= start_ff[`SSB_START_BIT];
            ref_d_ff <= sync_s2_ff[1];
        end
    end

    assign start_evt = (sync_s2_ff[0] && !en_d_ff)
        || (start_ff[`SSB_START_BIT] && !sw_d_ff);
    assign busy = state_ff != ssb_pkg::S_IDLE;

    ////////////////////////////////////////////////////////////////////////////
    // Chip and symbol timing

    // Divider restarts at burst start so the first chip is full length
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            div_cnt_ff <= 8'h00;
        end else if (!busy || div_cnt_ff == chdiv_ff) begin
            div_cnt_ff <= 8'h00;
        end else begin
            div_cnt_ff <= div_cnt_ff + 8'h01;
        end
    end

    assign chip_en = busy && (cfg_ff[`SSB_EXTREF_BIT] ? (sync_s2_ff[1] && !ref_d_ff)
        : (div_cnt_ff == chdiv_ff));

    // Zero length means a full 64-chip code; an oversized data length does too, but the preamble uses only its low six bits
    always_comb begin
        if (state_ff == ssb_pkg::S_PRE) begin
            sym_len = (pchip_ff[5:0] == 6'h00) ? `SSB_MAX_CHIPS : {1'b0, pchip_ff[5:0]};
        end else if (dchip_ff == 8'h00 || dchip_ff > {1'b0, `SSB_MAX_CHIPS}) begin
            sym_len = `SSB_MAX_CHIPS;
        end else begin
            sym_len = dchip_ff[6:0];
        end
    end

    assign sym_last = ({1'b0, idx_ff} == 7'(sym_len - 7'h01));
    assign code_bit = (state_ff == ssb_pkg::S_PRE) ? pcode_ff[idx_ff] : dcode_ff[idx_ff];

    ////////////////////////////////////////////////////////////////////////////
    // Differential encoder

    // Position on the 00,01,11,10 cycle
    function automatic logic [1:0] cyc_pos(input ssb_pkg::ssb_pair_t p);
        return {p.i, p.i ^ p.q};
    endfunction

    always_comb begin
        logic [1:0] np;
        np = 2'(cyc_pos(enc_ff) + cyc_pos(fetched_ff));
        if (bpsk_ff) begin
            enc_next.i = fetched_ff.i ^ enc_ff.i;
            enc_next.q = fetched_ff.i ^ enc_ff.i;
        end else begin
            enc_next.i = np[1];
            enc_next.q = np[1] ^ np[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Burst sequencer: one preamble symbol then the counted data symbols

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_ff <= ssb_pkg::S_IDLE;
            idx_ff <= 6'h00;
            enc_ff <= '0;
            remain_ff <= 16'h0000;
            bpsk_ff <= 1'b0;
            pre_done_ff <= 1'b0;
            data_pls_ff <= 1'b0;
        end else begin
            pre_done_ff <= 1'b0;
            data_pls_ff <= 1'b0;
            case (state_ff)
                ssb_pkg::S_IDLE: begin
                    if (start_evt) begin
                        state_ff <= ssb_pkg::S_PRE;
                        idx_ff <= 6'h00;
                        enc_ff <= '0;
                        remain_ff <= blen_ff;
                        bpsk_ff <= mode_ff[`SSB_BPSK_BIT];
                    end
                end
                default: begin
                    if (chip_en && sym_last) begin
                        idx_ff <= 6'h00;
                        if (state_ff == ssb_pkg::S_PRE) begin
                            pre_done_ff <= 1'b1;
                        end
                        if (remain_ff == 16'h0000) begin
                            state_ff <= ssb_pkg::S_IDLE;
                        end else begin
                            state_ff <= ssb_pkg::S_DATA;
                            remain_ff <= remain_ff - 16'h0001;
                            enc_ff <= enc_next;
                            data_pls_ff <= 1'b1;
                        end
                    end else if (chip_en) begin
                        idx_ff <= idx_ff + 6'h01;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bit fetch: requests the next symbol's bits while the current one is sent

    assign start_fetch = (!busy && start_evt && blen_ff != 16'h0000)
        || (chip_en && sym_last && remain_ff > 16'h0001);
    assign nbits = (busy ? bpsk_ff : mode_ff[`SSB_BPSK_BIT]) ? 2'h1 : 2'h2;

    // The source's bit is taken a fixed delay after each request
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            left_ff <= 2'h0;
            lat_ff <= 3'h0;
            slot_ff <= 1'b0;
            req_ff <= 1'b0;
            fetched_ff <= '0;
        end else begin
            req_ff <= 1'b0;
            if (start_fetch) begin
                left_ff <= nbits;
                lat_ff <= `SSB_BIT_LAT;
                slot_ff <= 1'b0;
                req_ff <= 1'b1;
            end else if (left_ff != 2'h0) begin
                if (lat_ff != 3'h0) begin
                    lat_ff <= lat_ff - 3'h1;
                end else begin
                    if (slot_ff) begin
                        fetched_ff.q <= sync_s2_ff[2];
                    end else begin
                        fetched_ff.i <= sync_s2_ff[2];
                    end
                    left_ff <= left_ff - 2'h1;
                    slot_ff <= 1'b1;
                    if (left_ff == 2'h2) begin
                        req_ff <= 1'b1;
                        lat_ff <= `SSB_BIT_LAT;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Spreader and modulator

    // Chips are zero between bursts
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            spread_i_ff <= 1'b0;
            spread_q_ff <= 1'b0;
        end else begin
            spread_i_ff <= busy && (enc_ff.i ^ code_bit);
            spread_q_ff <= busy && (enc_ff.q ^ code_bit);
        end
    end

    // NCO runs free on this clock, which is the IF clock
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            phase_ff <= 32'h0000_0000;
        end else begin
            phase_ff <= phase_ff + fcw_ff;
        end
    end

    ssb_sine_rom u_rom (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .phase_i(phase_ff[31:28]),
        .sin_o(nco_sin),
        .cos_o(nco_cos)
    );

    // Plain QPSK only: bit 0 is +1, so 00 lands in the first quadrant
    assign term_i = spread_i_ff ? -{nco_cos[7], nco_cos} : {nco_cos[7], nco_cos};
    assign term_q = spread_q_ff ? -{nco_sin[7], nco_sin} : {nco_sin[7], nco_sin};
    assign if_sum = 9'(term_i - term_q);

    // Halving keeps the sum within eight bits
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            if_ff <= 8'h00;
        end else begin
            if_ff <= busy ? if_sum[8:1] : 8'h00;
        end
    end

    assign tx_bit_request_o = req_ff;
    assign preamble_done_pulse_o = pre_done_ff;
    assign data_symbol_pulse_o = data_pls_ff;
    assign spread_i_out_o = spread_i_ff;
    assign spread_q_out_o = spread_q_ff;
    assign modulated_if_out_o = if_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_sym_end;
        busy && chip_en && sym_last;
    endsequence

    sequence s_pre_end;
        state_ff == ssb_pkg::S_PRE ##0 s_sym_end;
    endsequence

    a_dbpsk_xor: assert property (
        s_sym_end ##0 (remain_ff != 16'h0000 && bpsk_ff)
        |=> enc_ff.i == ($past(fetched_ff.i) ^ $past(enc_ff.i)))
        else $error("dbpsk encoding wrong");

    a_dqpsk_cycle: assert property (
        s_sym_end ##0 (remain_ff != 16'h0000 && !bpsk_ff)
        |=> cyc_pos(enc_ff) == 2'(cyc_pos($past(enc_ff)) + cyc_pos($past(fetched_ff))))
        else $error("dqpsk step wrong");

    a_burst_start: assert property (
        !busy && start_evt |=> state_ff == ssb_pkg::S_PRE && idx_ff == 6'h00)
        else $error("burst did not start with preamble");

    a_enc_clear: assert property (
        !busy && start_evt |=> enc_ff == 2'b00)
        else $error("encoder state not cleared");

    a_pre_done: assert property (
        s_pre_end |=> preamble_done_pulse_o ##1 !preamble_done_pulse_o)
        else $error("preamble done pulse wrong");

    a_bit_pair: assert property (
        start_fetch && nbits == 2'h2
        |=> tx_bit_request_o ##1 !tx_bit_request_o [*4] ##1 tx_bit_request_o)
        else $error("second bit request misplaced");

    a_spread_xor: assert property (
        busy |=> spread_i_out_o == ($past(enc_ff.i) ^ $past(code_bit)))
        else $error("spread chip wrong");

    a_bpsk_same: assert property (
        bpsk_ff && state_ff == ssb_pkg::S_DATA |=> spread_q_out_o == spread_i_out_o)
        else $error("bpsk channels differ");

    a_burst_stop: assert property (
        s_sym_end ##0 remain_ff == 16'h0000 |=> state_ff == ssb_pkg::S_IDLE ##1 !busy)
        else $error("burst did not stop");
endmodule

// ---- verification/ssb_bit_source.sv ----
// Serial data source model answering bit requests
`timescale 1ns/1ns
module ssb_bit_source (
    // Clock, reset, restart
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic load_i,
    // Request in, bits to send, data out
    input wire logic tx_bit_request_i,
    input wire logic [15:0] bits_i,
    output logic tx_serial_o
);
    logic [3:0] k_ff;
    // Next bit on each request, held until the following one so capture lag is harmless
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            k_ff <= 4'h0;
            tx_serial_o <= 1'b0;
        end else if (load_i) begin
            k_ff <= 4'h0;
            tx_serial_o <= 1'b0;
        end else if (tx_bit_request_i) begin
            tx_serial_o <= bits_i[k_ff];
            k_ff <= k_ff + 4'h1;
        end
    end
endmodule

// ---- verification/tb_top.sv ----
// Self-checking bench for the burst transmitter
`timescale 1ns/1ns
`include "ssb_params.svh"
module tb_top;
    logic clock_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic hsel, hwrite, pin, load, req, pdone, dsym, si, so, sq, hrdy, hresp;
    logic xref = 1'b0;
    logic si_d = 1'b0;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [15:0] bits;
    logic [15:0] lfsr = 16'h000C;
    logic [7:0] ifo;
    int failures = 0;
    int samples_checked = 0;
    int cyc = 0;
    int nreq, npd, nds, nhi, nhq, nif, nq24;
    ////////////////////////////////////////////////////////////////////////////
    ssb_burst_tx DUT (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
        .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy),
        .hresp_o(hresp), .tx_burst_enable_pin_i(pin), .ext_tx_chip_ref_i(xref),
        .tx_serial_in_i(so), .tx_bit_request_o(req), .preamble_done_pulse_o(pdone),
        .data_symbol_pulse_o(dsym), .spread_i_out_o(si), .spread_q_out_o(sq),
        .modulated_if_out_o(ifo));
    ssb_bit_source SRC (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .load_i(load),
        .tx_bit_request_i(req), .bits_i(bits), .tx_serial_o(so));
    ////////////////////////////////////////////////////////////////////////////
    // Clock
    always #4 clock_i = ~clock_i;
    // Tally pulses and high chip cycles; cut a hang short
    always @(posedge clock_i) begin
        cyc++;
        nreq += req;
        npd += pdone;
        nds += dsym;
        // Bench clock is far above the internal modulator limit, so the pins are scored
        nhi += si;
        nhq += sq;
        // Second and fourth quadrants are I and Q unequal
        nq24 += si ^ sq;
        // Chip reference: one rising edge every four clocks
        if (cyc[0]) xref <= ~xref;
        // NCO word stays zero in bursts: cos full scale, sin zero, so the sign follows I
        if (!sys_rst_i && ifo !== 8'h00) begin
            nif++;
            check("if sample", {24'h0, ifo}, {24'h0, si_d ? 8'hC0 : 8'h3F});
        end
        si_d <= si;
        if (cyc == 20000) begin
            failures++;
            conclude();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    // One single AHB transfer; waits on hready, so any wait state count works
    task automatic bus(logic w, logic [7:0] idx, logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {22'h0, idx, 2'h0};
        @(posedge clock_i);
        while (hrdy !== 1'b1) @(posedge clock_i);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge clock_i);
        while (hrdy !== 1'b1) @(posedge clock_i);
        rd = hrdata;
    endtask
    function automatic logic [15:0] lfsr_next(logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // Pair to ring position on 00,01,11,10 and back (its own inverse)
    function automatic logic [1:0] ring(logic [1:0] p);
        return {p[1], p[1] ^ p[0]};
    endfunction
    // Whole-burst high-cycle counts make the check immune to output latency
    // Preamble code has four high chips of eight, data code four of six
    task automatic burst(logic bpsk, logic usepin, int per);
        logic [1:0] e;
        int ei, eq;
        e = 2'h0;
        ei = 4 * per;
        eq = 4 * per;
        for (int s = 0; s < 3; s++) begin
            if (bpsk) e = {2{bits[s] ^ e[1]}};
            else e = ring(ring(e) + ring({bits[2*s], bits[2*s+1]}));
            ei += e[1] ? 2 * per : 4 * per;
            eq += e[0] ? 2 * per : 4 * per;
        end
        bus(1, `SSB_IDX_MODE, {31'h0, bpsk});
        load <= 1'b1;
        @(posedge clock_i);
        load <= 1'b0;
        {nreq, npd, nds, nhi, nhq, nif, nq24} = '0;
        if (usepin) pin <= 1'b1;
        else bus(1, `SSB_IDX_START, 32'h2);
        repeat (400) @(posedge clock_i);
        pin <= 1'b0;
        bus(1, `SSB_IDX_START, 32'h0);
        check("bit requests", nreq, bpsk ? 3 : 6);
        check("preamble done", npd, 1);
        check("data symbols", nds, 3);
        check("i chips", nhi, ei);
        check("q chips", nhq, eq);
        if (bpsk) check("off quadrants", nq24, 0);
        // The first chip on the reference is of uneven length, so count only divided bursts
        if (per == 8) check("if samples", nif, (8 + 3 * 6) * per);
        $display("burst test done");
    endtask
    task automatic conclude();
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence: registers, five bursts over both starts and modes, one on the chip reference
    initial begin
        {hsel, hwrite, pin, load, htrans, haddr, hwdata, bits} = '0;
        repeat (3) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        @(posedge clock_i);
        bus(0, `SSB_IDX_CHDIV, 0);
        check("chip divider", rd, 32'h7);
        bus(0, `SSB_IDX_BLEN0, 0);
        check("burst length", rd, 32'h4);
        bus(0, 8'h70, 0);
        check("unmapped", rd, 32'h0);
        check("response", {31'h0, hresp}, 32'h0);
        bus(1, `SSB_IDX_PCHIPS, 8);
        bus(1, `SSB_IDX_PCODE0, 32'h5A);
        bus(1, `SSB_IDX_DCHIPS, 6);
        bus(1, `SSB_IDX_DCODE0, 32'h1E);
        bus(1, `SSB_IDX_BLEN0, 3);
        bus(0, `SSB_IDX_DCODE0, 0);
        check("data code", rd, 32'h1E);
        $display("register test done");
        for (int t = 0; t < 5; t++) begin
            lfsr = lfsr_next(lfsr);
            bits = (t == 4) ? 16'hFFFF : lfsr;
            if (t == 4) bus(1, `SSB_IDX_CFG, 1);
            burst(t[0], t[1], (t == 4) ? 4 : 8);
        end
        // Frequency word last, so the NCO stays at zero phase through the bursts
        bus(1, `SSB_IDX_FCW0, {24'h0, lfsr[7:0]});
        bus(0, `SSB_IDX_FCW0, 0);
        check("frequency word", rd, {24'h0, lfsr[7:0]});
        $display("frequency word test done");
        conclude();
    end
endmodule
